/* core/ces_defs.svh */
// Register indices, field positions, reset values and timing counts of the shadow configuration block
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH

// register indices; the byte address on APB is four times the index
`define CES_IDX_CFG_LAST  8'h4B
`define CES_IDX_WIN_LAST  8'h57
`define CES_IDX_CTRL2     8'h87
`define CES_IDX_SEL       8'h89
`define CES_IDX_STAT      8'h8F

`define CES_CFG_BYTES     76
`define CES_NVM_BYTES     88

`define CES_SEL_BIT       0
`define CES_SEL_RESET     1'b0
`define CES_CTRL2_RESET   3'h0
`define CES_CTRL2_OVR     0
`define CES_CTRL2_CFET    1
`define CES_CTRL2_DFET    2

`define CES_STAT_CORR     0
`define CES_STAT_UNC      1
`define CES_STAT_DONE     2
`define CES_STAT_BUSY     3
`define CES_STAT_BAD      4

`define CES_NVM_WR_MS     30
`define CES_CLK_HZ        10000000
`define CES_NVM_WR_CYC    (`CES_NVM_WR_MS * (`CES_CLK_HZ / 1000))

`endif

/* core/ces_pkg.sv */
// Types shared by the shadow configuration block
package ces_pkg;

	typedef logic [7:0]  ces_byte_t;
	typedef logic [12:0] ces_code_t;

	typedef enum logic [2:0] {
		RC_IDLE,
		RC_ISSUE,
		RC_WAIT,
		RC_CHECK,
		RC_DONE
	} ces_recall_t;

endpackage : ces_pkg

/* core/ces_nvm_array.sv */
// Nonvolatile array with single-error correction, double-error detection and a timed write cycle
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module ces_nvm_array
	import ces_pkg::*;
#(
	parameter int WR_CYC = `CES_NVM_WR_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        rd_req,
	input  wire logic        wr_req,
	input  wire logic [6:0]  addr,
	input  wire ces_byte_t   wdata,
	input  wire ces_code_t   err_inject,
	output logic             rd_valid,
	output ces_byte_t        rd_data,
	output logic             rd_corr,
	output logic             rd_fail,
	output logic             busy
);

	// zero data with zero check bits is a valid codeword
	ces_code_t   mem [0:`CES_NVM_BYTES-1] = '{default: '0};
	logic [23:0] wr_cnt;
	logic [9:0]  dec;

	function automatic logic [3:0] ecc_syn(input logic [12:1] c);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 1; i <= 12; i++) begin
			if (c[i]) begin
				s = s ^ 4'(i);
			end
		end
		return s;
	endfunction : ecc_syn

	function automatic ces_code_t ecc_enc(input ces_byte_t d);
		logic [12:1] c;
		logic [3:0]  s;
		c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'h0};
		s = ecc_syn(c);
		c[1] = s[0];
		c[2] = s[1];
		c[4] = s[2];
		c[8] = s[3];
		return {^c, c};
	endfunction : ecc_enc

	// returns {fail, corrected, data}
	function automatic logic [9:0] ecc_dec(input ces_code_t w);
		logic [12:1] c;
		logic [3:0]  s;
		logic        corr;
		logic        fail;
		c = w[11:0];
		s = ecc_syn(c);
		corr = 1'b0;
		fail = 1'b0;
		if (^w) begin
			corr = 1'b1;
			if (s > 4'hC) begin
				fail = 1'b1;
				corr = 1'b0;
			end else if (s != 4'h0) begin
				c[s] = ~c[s];
			end
		end else if (s != 4'h0) begin
			fail = 1'b1;
		end
		return {fail, corr, c[12:9], c[7:5], c[3]};
	endfunction : ecc_dec

	// test hook: err_inject flips stored bits so that corrections can be provoked
	always_ff @(posedge pclk) begin
		if (wr_req && !busy) begin
			mem[addr] <= ecc_enc(wdata) ^ err_inject;
		end
	end

	assign dec = ecc_dec(mem[addr]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
			rd_corr  <= 1'b0;
			rd_fail  <= 1'b0;
		end else begin
			rd_valid <= rd_req;
			if (rd_req) begin
				rd_data <= dec[7:0];
				rd_corr <= dec[8];
				rd_fail <= dec[9];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_cnt <= 24'h000000;
		end else if (wr_req && !busy) begin
			wr_cnt <= 24'(WR_CYC);
		end else if (busy) begin
			wr_cnt <= wr_cnt - 24'h000001;
		end
	end

	assign busy = (wr_cnt != 24'h000000);

endmodule : ces_nvm_array
`default_nettype wire

/* core/ces_shadow_ctrl.sv */
// Shadow configuration registers, power-on recall and nonvolatile access over APB
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module ces_shadow_ctrl
	import ces_pkg::*;
#(
	parameter int NVM_WR_CYC = `CES_NVM_WR_CYC
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         power_down,
	input  wire logic         cell_lockout_fault,
	input  wire logic         short_circuit_fault,
	input  wire logic         internal_overtemp_fault,
	input  wire logic         in_sleep,
	input  wire logic         forced_off_input,
	input  wire ces_code_t    nvm_err_inject,
	output logic [607:0]      config_shadow,
	output logic              recall_done,
	output logic              charge_fet_on,
	output logic              discharge_fet_on
);

	logic [5:0]  pin_m;
	logic [5:0]  pin_s;
	logic        pd_s;
	logic        hard_off;
	ces_byte_t   shadow [0:`CES_CFG_BYTES-1];
	logic        nvm_select;
	logic [2:0]  ctrl2;
	logic        ecc_corrected;
	logic        ecc_uncorrectable;
	ces_recall_t rc_st;
	logic [6:0]  rc_idx;
	logic        recall_bad;
	logic        rc_req;
	logic [7:0]  idx;
	logic        hi_ok;
	logic        in_win;
	logic        in_cfg;
	logic        nv_path;
	logic        mapped;
	logic        refuse;
	logic        acc;
	logic        is_nvrd;
	logic        host_rd;
	logic        host_wr;
	logic        reg_wr;
	logic        rd_pend;
	logic        rd_done;
	ces_byte_t   reg_rd;
	logic        nvm_rd_req;
	logic [6:0]  nvm_addr;
	logic        nvm_rd_valid;
	ces_byte_t   nvm_rd_data;
	logic        nvm_rd_corr;
	logic        nvm_rd_fail;
	logic        nvm_busy;

	// pins are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_m <= 6'h00;
			pin_s <= 6'h00;
		end else begin
			pin_m <= {power_down, forced_off_input, in_sleep,
				internal_overtemp_fault, short_circuit_fault, cell_lockout_fault};
			pin_s <= pin_m;
		end
	end

	assign pd_s     = pin_s[5];
	assign hard_off = |pin_s[4:0];

	// address decode
	assign idx     = paddr[9:2];
	assign hi_ok   = (paddr[11:10] == 2'h0);
	assign in_win  = hi_ok && (idx <= `CES_IDX_WIN_LAST);
	assign in_cfg  = in_win && (idx <= `CES_IDX_CFG_LAST);
	assign nv_path = in_win && nvm_select;
	assign mapped  = in_win || (hi_ok && (idx == `CES_IDX_CTRL2 || idx == `CES_IDX_SEL || idx == `CES_IDX_STAT));
	assign refuse  = nv_path && (!recall_done || nvm_busy);
	assign acc     = psel && penable;
	assign is_nvrd = nv_path && !pwrite && !refuse;
	assign host_rd = acc && is_nvrd && !rd_pend && !rd_done;
	assign host_wr = acc && pwrite && nv_path && !refuse;
	assign reg_wr  = acc && pwrite && hi_ok;

	// register reads need no wait; array reads wait for the array
	assign pready  = acc && (!is_nvrd || rd_done);
	assign pslverr = pready && (!mapped || refuse);

	assign rc_req     = (rc_st == RC_ISSUE);
	assign nvm_rd_req = host_rd || rc_req;
	assign nvm_addr   = recall_done ? idx[6:0] : rc_idx;

	always_comb begin
		reg_rd = 8'h00;
		if (in_cfg && !nvm_select) begin
			reg_rd = shadow[idx[6:0]];
		end else if (hi_ok && idx == `CES_IDX_CTRL2) begin
			reg_rd = {5'h00, ctrl2};
		end else if (hi_ok && idx == `CES_IDX_SEL) begin
			reg_rd[`CES_SEL_BIT] = nvm_select;
		end else if (hi_ok && idx == `CES_IDX_STAT) begin
			reg_rd[`CES_STAT_CORR] = ecc_corrected;
			reg_rd[`CES_STAT_UNC]  = ecc_uncorrectable;
			reg_rd[`CES_STAT_DONE] = recall_done;
			reg_rd[`CES_STAT_BUSY] = nvm_busy;
			reg_rd[`CES_STAT_BAD]  = recall_bad;
		end
	end

	// user area in the window reads zero here: it has no shadow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_pend && nvm_rd_valid) begin
			prdata <= {24'h000000, nvm_rd_data};
		end else if (psel && !penable) begin
			prdata <= {24'h000000, reg_rd};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pend <= 1'b0;
			rd_done <= 1'b0;
		end else begin
			if (host_rd) begin
				rd_pend <= 1'b1;
			end else if (nvm_rd_valid) begin
				rd_pend <= 1'b0;
			end
			rd_done <= rd_pend && nvm_rd_valid;
		end
	end

	// select bit never clears itself; software has to write it back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_select <= `CES_SEL_RESET;
			ctrl2      <= `CES_CTRL2_RESET;
		end else begin
			if (reg_wr && idx == `CES_IDX_SEL) begin
				nvm_select <= pwdata[`CES_SEL_BIT];
			end
			if (reg_wr && idx == `CES_IDX_CTRL2) begin
				ctrl2 <= pwdata[2:0];
			end
		end
	end

	// one update per completed array read, host or recall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ecc_corrected     <= 1'b0;
			ecc_uncorrectable <= 1'b0;
		end else if (nvm_rd_valid) begin
			ecc_corrected     <= nvm_rd_corr;
			ecc_uncorrectable <= nvm_rd_fail;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `CES_CFG_BYTES; i++) begin
				shadow[i] <= 8'h00;
			end
		end else if (pd_s) begin
			for (int i = 0; i < `CES_CFG_BYTES; i++) begin
				shadow[i] <= 8'h00;
			end
		end else if (rc_st == RC_WAIT && nvm_rd_valid) begin
			if (!nvm_rd_fail) begin
				shadow[rc_idx] <= nvm_rd_data;
			end
		end else if (acc && pwrite && in_cfg && !nvm_select) begin
			shadow[idx[6:0]] <= pwdata[7:0];
		end
	end

	// recall walks only the configuration area; a failed word keeps its old value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_st       <= RC_IDLE;
			rc_idx      <= 7'h00;
			recall_done <= 1'b0;
			recall_bad  <= 1'b0;
		end else if (pd_s) begin
			rc_st       <= RC_IDLE;
			recall_done <= 1'b0;
		end else begin
			case (rc_st)
				RC_IDLE: begin
					rc_idx     <= 7'h00;
					recall_bad <= 1'b0;
					rc_st      <= RC_ISSUE;
				end
				RC_ISSUE: begin
					rc_st <= RC_WAIT;
				end
				RC_WAIT: begin
					if (nvm_rd_valid) begin
						rc_st <= RC_CHECK;
					end
				end
				RC_CHECK: begin
					if (ecc_uncorrectable) begin
						recall_bad <= 1'b1;
					end
					if ({1'b0, rc_idx} == `CES_IDX_CFG_LAST) begin
						rc_st       <= RC_DONE;
						recall_done <= 1'b1;
					end else begin
						rc_idx <= rc_idx + 7'h01;
						rc_st  <= RC_ISSUE;
					end
				end
				RC_DONE: begin
					rc_st <= RC_DONE;
				end
				default: begin
					rc_st <= RC_IDLE;
				end
			endcase
		end
	end

	// device logic sees only the shadows
	for (genvar g = 0; g < `CES_CFG_BYTES; g++) begin : g_flat
		assign config_shadow[g*8 +: 8] = shadow[g];
	end

	// negative control: on by default, held off until recall is confirmed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charge_fet_on    <= 1'b0;
			discharge_fet_on <= 1'b0;
		end else if (!recall_done || hard_off) begin
			charge_fet_on    <= 1'b0;
			discharge_fet_on <= 1'b0;
		end else if (ctrl2[`CES_CTRL2_OVR]) begin
			charge_fet_on    <= ctrl2[`CES_CTRL2_CFET];
			discharge_fet_on <= ctrl2[`CES_CTRL2_DFET];
		end else begin
			charge_fet_on    <= 1'b1;
			discharge_fet_on <= 1'b1;
		end
	end

	ces_nvm_array #(
		.WR_CYC(NVM_WR_CYC)
	) u_nvm (
		.pclk       (pclk),
		.presetn    (presetn),
		.rd_req     (nvm_rd_req),
		.wr_req     (host_wr),
		.addr       (nvm_addr),
		.wdata      (pwdata[7:0]),
		.err_inject (nvm_err_inject),
		.rd_valid   (nvm_rd_valid),
		.rd_data    (nvm_rd_data),
		.rd_corr    (nvm_rd_corr),
		.rd_fail    (nvm_rd_fail),
		.busy       (nvm_busy)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_recall_end; $rose(recall_done) |-> ({1'b0, rc_idx} == `CES_IDX_CFG_LAST); endproperty
	a_recall_end: assert property (p_recall_end) else $error("recall ended early");
	property p_sel_src; $changed(nvm_select) |-> $past(reg_wr && idx == `CES_IDX_SEL); endproperty
	a_sel_src: assert property (p_sel_src) else $error("select changed without write");
	property p_route; host_rd |-> ##2 (pready && !pslverr && prdata[7:0] == $past(nvm_rd_data)); endproperty
	a_route: assert property (p_route) else $error("array read not answered in two cycles");
	property p_cfg_wr;
		acc && pwrite && in_cfg && !nvm_select && !pd_s && rc_st != RC_WAIT
		|-> !host_wr ##1 shadow[$past(idx[6:0])] == $past(pwdata[7:0]);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("shadow write lost");
	property p_nv_wr; host_wr |=> $stable(config_shadow); endproperty
	a_nv_wr: assert property (p_nv_wr) else $error("array write touched shadows");
	property p_pd; pd_s |=> (config_shadow == '0) && !recall_done; endproperty
	a_pd: assert property (p_pd) else $error("powerdown kept shadows");
	property p_fail_keep; rc_st == RC_WAIT && nvm_rd_valid && nvm_rd_fail && !pd_s |=> $stable(config_shadow); endproperty
	a_fail_keep: assert property (p_fail_keep) else $error("failed word overwrote shadow");
	property p_gate; !recall_done |=> !charge_fet_on && !discharge_fet_on; endproperty
	a_gate: assert property (p_gate) else $error("switch on before recall");
	property p_neg; recall_done && !hard_off && !ctrl2[`CES_CTRL2_OVR] |=> charge_fet_on && discharge_fet_on; endproperty
	a_neg: assert property (p_neg) else $error("switch off without fault");
	property p_hard; recall_done && hard_off |=> !charge_fet_on && !discharge_fet_on; endproperty
	a_hard: assert property (p_hard) else $error("fault did not force switches off");
	property p_corr; nvm_rd_valid && nvm_rd_corr |=> ecc_corrected && !ecc_uncorrectable; endproperty
	a_corr: assert property (p_corr) else $error("corrected flag wrong");
	property p_fail; nvm_rd_valid && nvm_rd_fail |=> !ecc_corrected && ecc_uncorrectable; endproperty
	a_fail: assert property (p_fail) else $error("uncorrectable flag wrong");
	property p_clean; nvm_rd_valid && !nvm_rd_corr && !nvm_rd_fail |=> !ecc_corrected && !ecc_uncorrectable; endproperty
	a_clean: assert property (p_clean) else $error("flags not cleared by clean read");
	property p_hold; !nvm_rd_valid |=> $stable({ecc_corrected, ecc_uncorrectable}); endproperty
	a_hold: assert property (p_hold) else $error("flags moved without a read");
	property p_busy; acc && nv_path && nvm_busy |-> pready && pslverr && !nvm_rd_req && !host_wr; endproperty
	a_busy: assert property (p_busy) else $error("request taken during write cycle");
	property p_user; acc && !pwrite && !nvm_select && in_win && !in_cfg |-> pready && prdata == 32'h00000000; endproperty
	a_user: assert property (p_user) else $error("user area has a shadow");
	property p_page; acc && !pwrite && in_cfg && !nvm_select |-> pready && !pslverr; endproperty
	a_page: assert property (p_page) else $error("shadow read stalled");

	c_recall: cover property ($rose(recall_done));
	c_nv_corr: cover property (rd_done && ecc_corrected);
	c_refused: cover property (acc && nv_path && nvm_busy);
	c_cfg_wr: cover property (acc && pwrite && in_cfg && !nvm_select);

endmodule : ces_shadow_ctrl
`default_nettype wire

/* dv/ces_apb_host.sv */
// APB master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module ces_apb_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        req,
	input  wire logic        rq_write,
	input  wire logic [11:0] rq_addr,
	input  wire logic [31:0] rq_wdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic             done,
	output logic [31:0]      rdata,
	output logic             err
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= 1'b0;
			paddr <= 12'hFFF;
			pwdata <= 32'hFFFFFFFF;
			done <= 1'b0;
			rdata <= 32'h0;
			err <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!psel && req) begin
				psel <= 1'b1;
				pwrite <= rq_write;
				paddr <= rq_addr;
				pwdata <= rq_wdata;
			end else if (psel && !penable) begin
				penable <= 1'b1;
			end else if (penable && pready) begin
				psel <= 1'b0;
				penable <= 1'b0;
				done <= 1'b1;
				rdata <= prdata;
				err <= pslverr;
				// released lines must not keep showing the last value
				paddr <= ~paddr;
				pwdata <= ~pwdata;
				pwrite <= ~pwrite;
			end
		end
	end
endmodule : ces_apb_host
`default_nettype wire

/* dv/tb_config_eeprom_shadow_access.sv */
// Self-checking bench for the shadow configuration block
`timescale 1ns/10ps
`default_nettype none
`include "ces_defs.svh"
module tb_config_eeprom_shadow_access
	import ces_pkg::*;
;
	localparam int WR = 20;
	logic pclk = 1'b0;
	logic presetn, req, rq_write, psel, penable, pwrite, pready, pslverr, done, err, e;
	logic power_down, recall_done, cfet, dfet;
	logic [11:0] rq_addr, paddr;
	logic [31:0] rq_wdata, pwdata, prdata, rdata, r;
	logic [4:0] fault;
	ces_code_t inj;
	ces_code_t ij[4];
	logic [607:0] shadow;
	logic [7:0] a;
	logic [7:0] v[4];
	logic [7:0] pg[4];
	logic [7:0] ix[4];
	integer mismatches, n_checks, seed;

	always #50 pclk = ~pclk;

	ces_apb_host u_ces_apb_host (.pclk(pclk), .presetn(presetn), .req(req), .rq_write(rq_write),
		.rq_addr(rq_addr), .rq_wdata(rq_wdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.done(done), .rdata(rdata), .err(err));

	ces_shadow_ctrl #(.NVM_WR_CYC(WR)) u_ces_shadow_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .power_down(power_down), .cell_lockout_fault(fault[0]),
		.short_circuit_fault(fault[1]), .internal_overtemp_fault(fault[2]), .in_sleep(fault[3]),
		.forced_off_input(fault[4]), .nvm_err_inject(inj), .config_shadow(shadow),
		.recall_done(recall_done), .charge_fet_on(cfet), .discharge_fet_on(dfet));

	function automatic logic [1:0] fets(input logic [4:0] f, input logic [2:0] c);
		if (f != 5'h00)
			return 2'b00;
		return c[0] ? c[2:1] : 2'b11;
	endfunction : fets

	function automatic logic [31:0] st(input logic c, input logic u, input logic b);
		return {27'h0, b, 1'b0, 1'b1, u, c};
	endfunction : st

	function automatic logic [7:0] byte_of(input logic [607:0] sv, input int i);
		return sv[8*i +: 8];
	endfunction : byte_of

	task automatic conclude();
		$display("mismatches %0d n_checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge pclk);
		req <= 1'b1;
		rq_write <= w;
		rq_addr <= {2'b00, idx, 2'b00};
		rq_wdata <= {24'($random(seed)), d};
		@(posedge pclk);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 50);
		chk({31'h0, done}, 32'h1, "no answer");
		r = rdata;
		e = err;
	endtask : apb

	task automatic wx(input logic [7:0] idx, input logic [7:0] d, input logic ee);
		apb(1'b1, idx, d);
		chk({31'h0, e}, {31'h0, ee}, "write resp");
	endtask : wx

	task automatic rx(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
		apb(1'b0, idx, 8'h00);
		chk({31'h0, e}, {31'h0, ee}, "read resp");
		chk(r, exp, "read data");
	endtask : rx

	task automatic waitr();
		int n;
		n = 0;
		while (recall_done !== 1'b1 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		#1;
		chk({31'h0, recall_done}, 32'h1, "recall done");
	endtask : waitr

	task automatic wait5();
		repeat (5) @(posedge pclk);
		#1;
	endtask : wait5

	initial begin
		#3000000;
		mismatches++;
		conclude();
	end

	initial begin
		{req, rq_write, rq_addr, rq_wdata, power_down, fault, inj, presetn} = '0;
		mismatches = 0;
		n_checks = 0;
		seed = 28668;
		repeat (4) @(posedge pclk);
		chk({31'h0, recall_done}, 32'h0, "recall in reset");
		presetn <= 1'b1;
		wx(`CES_IDX_SEL, 8'h01, 1'b0);
		rx(8'h04, 32'h0, 1'b1);
		wx(`CES_IDX_SEL, 8'h00, 1'b0);
		waitr();
		chk({31'h0, shadow === '0}, 32'h1, "recalled zero");
		wait5();
		chk({30'h0, dfet, cfet}, {30'h0, fets(5'h00, 3'h0)}, "fets on");
		rx(`CES_IDX_SEL, 32'h0, 1'b0);
		rx(8'hC0, 32'h0, 1'b1);
		wx(8'hC0, 8'h55, 1'b1);
		a = 8'h20 | (8'($random(seed)) & 8'h1C);
		for (int i = 0; i < 4; i++) begin
			pg[i] = 8'($random(seed));
			wx(a + 8'(i), pg[i], 1'b0);
			chk({24'h0, byte_of(shadow, a + i)}, {24'h0, pg[i]}, "shadow now");
		end
		for (int i = 0; i < 4; i++)
			rx(a + 8'(i), {24'h0, pg[i]}, 1'b0);
		wx(8'h50, 8'h5A, 1'b0);
		rx(8'h50, 32'h0, 1'b0);
		wx(`CES_IDX_SEL, 8'h01, 1'b0);
		rx(a, 32'h0, 1'b0);
		rx(a, 32'h0, 1'b0);
		ix = '{a, 8'h10, 8'h11, 8'h50};
		ij = '{13'h0000, 13'h0001, 13'h0003, 13'h0000};
		for (int i = 0; i < 4; i++) begin
			v[i] = 8'($random(seed));
			inj <= ij[i];
			wx(ix[i], v[i], 1'b0);
			inj <= 13'h0000;
			// spacing keeps the next access out of the write cycle
			repeat (WR + 5) @(posedge pclk);
		end
		wx(8'h52, 8'hFF, 1'b0);
		wx(8'h52, 8'h00, 1'b1);
		repeat (WR + 5) @(posedge pclk);
		rx(8'h52, 32'hFF, 1'b0);
		chk({24'h0, byte_of(shadow, a)}, {24'h0, pg[0]}, "shadow kept");
		rx(a, {24'h0, v[0]}, 1'b0);
		rx(a, {24'h0, v[0]}, 1'b0);
		rx(`CES_IDX_STAT, st(1'b0, 1'b0, 1'b0), 1'b0);
		rx(8'h10, {24'h0, v[1]}, 1'b0);
		rx(8'h10, {24'h0, v[1]}, 1'b0);
		rx(`CES_IDX_STAT, st(1'b1, 1'b0, 1'b0), 1'b0);
		apb(1'b0, 8'h11, 8'h00);
		chk({31'h0, e}, 32'h0, "double resp");
		rx(`CES_IDX_STAT, st(1'b0, 1'b1, 1'b0), 1'b0);
		rx(8'h50, {24'h0, v[3]}, 1'b0);
		rx(8'h50, {24'h0, v[3]}, 1'b0);
		rx(`CES_IDX_STAT, st(1'b0, 1'b0, 1'b0), 1'b0);
		wx(`CES_IDX_SEL, 8'h00, 1'b0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		waitr();
		chk({24'h0, byte_of(shadow, a)}, {24'h0, v[0]}, "recall clean");
		chk({24'h0, byte_of(shadow, 8'h10)}, {24'h0, v[1]}, "recall fixed");
		chk({24'h0, byte_of(shadow, 8'h11)}, 32'h0, "recall kept");
		// array holds v[3] at 0x50, the register path must still read zero
		rx(8'h50, 32'h0, 1'b0);
		rx(`CES_IDX_SEL, 32'h0, 1'b0);
		rx(`CES_IDX_STAT, st(1'b0, 1'b0, 1'b1), 1'b0);
		power_down <= 1'b1;
		repeat (10) @(posedge pclk);
		#1;
		chk({30'h0, shadow === '0, recall_done}, 32'h2, "powerdown");
		power_down <= 1'b0;
		waitr();
		chk({24'h0, byte_of(shadow, a)}, {24'h0, v[0]}, "rerecall");
		for (int i = 0; i < 6; i++) begin
			fault <= (i < 5) ? 5'h01 << i : 5'h00;
			wait5();
			chk({30'h0, dfet, cfet}, {30'h0, fets(fault, 3'h0)}, "fault fets");
		end
		wx(`CES_IDX_CTRL2, 8'h03, 1'b0);
		wait5();
		chk({30'h0, dfet, cfet}, {30'h0, fets(5'h00, 3'h3)}, "override");
		fault <= 5'h02;
		wait5();
		chk({30'h0, dfet, cfet}, {30'h0, fets(5'h02, 3'h3)}, "hard fault");
		conclude();
	end
endmodule : tb_config_eeprom_shadow_access
`default_nettype wire
